// ### core/dma_serial_pkg.sv
// Purpose: constants shared by the dma serial port
// Assumes: byte-addressed register map, 32-bit register data
// Notes: event flags are indexed by the EV_* constants
package dma_serial_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 16;
  localparam int DIV_W = 16;
  localparam int NUM_EV = 11;
  // task trigger offsets
  localparam logic [11:0] TASK_BEGIN_RX = 12'h000;
  localparam logic [11:0] TASK_HALT_RX = 12'h004;
  localparam logic [11:0] TASK_BEGIN_TX = 12'h008;
  localparam logic [11:0] TASK_HALT_TX = 12'h00c;
  localparam logic [11:0] TASK_DRAIN = 12'h02c;
  // event flag index and offset
  localparam int EV_CTS = 0;
  localparam int EV_NCTS = 1;
  localparam int EV_ARRIVED = 2;
  localparam int EV_RX_END = 3;
  localparam int EV_SENT = 4;
  localparam int EV_TX_END = 5;
  localparam int EV_ERROR = 6;
  localparam int EV_RX_TIMEOUT = 7;
  localparam int EV_RX_BEGAN = 8;
  localparam int EV_TX_BEGAN = 9;
  localparam int EV_TX_HALTED = 10;
  localparam logic [NUM_EV-1:0][11:0] EV_ADDR = {12'h158, 12'h150, 12'h14c, 12'h144, 12'h124, 12'h120,
    12'h11c, 12'h110, 12'h108, 12'h104, 12'h100};
  // plain registers
  localparam logic [11:0] REG_ERR_SRC = 12'h480;
  localparam logic [11:0] REG_ENABLE = 12'h500;
  localparam logic [11:0] REG_BAUD_DIV = 12'h524;
  localparam logic [11:0] REG_RX_ADDR = 12'h534;
  localparam logic [11:0] REG_RX_LIMIT = 12'h538;
  localparam logic [11:0] REG_RX_AMOUNT = 12'h53c;
  localparam logic [11:0] REG_TX_ADDR = 12'h544;
  localparam logic [11:0] REG_TX_COUNT = 12'h548;
  localparam logic [11:0] REG_TX_AMOUNT = 12'h54c;
  localparam logic [11:0] REG_CONFIG = 12'h56c;
  // field layout
  localparam logic [3:0] ENABLE_ON = 4'h4;
  localparam int CFG_FC_BIT = 0;
  localparam int CFG_PAR_LSB = 1;
  localparam int CFG_STOP_BIT = 4;
  localparam int CFG_ODD_BIT = 8;
  localparam logic [2:0] PARITY_ON = 3'h7;
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_PARITY = 1;
  localparam int ERR_FRAMING = 2;
  localparam int ERR_BREAK = 3;
  // timing
  localparam longint CLK_HZ = 250000000;
  localparam longint MAX_BAUD_BPS = 1000000;
  localparam logic [DIV_W-1:0] MIN_BIT_CYCLES = DIV_W'(CLK_HZ / MAX_BAUD_BPS);
  localparam logic [3:0] FRAME_BASE_BITS = 4'ha;
  localparam int FLOW_MARGIN = 4;
  localparam logic [2:0] GRACE_BYTES = 3'h4;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FETCH = 2'b01,
    TX_WAIT = 2'b10,
    TX_SHIFT = 2'b11
  } tx_state_type;
  typedef enum logic [2:0] {
    RX_OFF = 3'b000,
    RX_RUN = 3'b001,
    RX_GRACE = 3'b010,
    RX_DRAIN = 3'b011,
    RX_TIMEOUT = 3'b100,
    RX_FLUSH = 3'b101
  } rx_state_type;
endpackage

// ### core/dma_serial_port.sv
// Purpose: full-duplex serial port moving bytes to and from ram by dma
// Assumes: one clock; link pins sampled on ref_clk_i; byte-wide ram port
// Notes: bit time is set in clock cycles by the divisor register
// Behaviour
// - full duplex, lsb first, hardware flow control
// - addresses and counts double buffered at start
// - start transmit fetches bytes from set address
// - byte sent event per transmitted byte
// - transmit ends itself after programmed count
// - halt transmit stops, then halted event
// - early stop still raises transmit end
// - cts low pauses between bytes only
// - receive writes buffer, end when full
// - byte arrived event per received byte
// - amount counts bytes since last end
// - halt receive: end first, then timeout
// - early stop still raises receive end
// - four byte times accepted after halt
// - drain task empties fifo, raises end
// - rts drops on halt or fifo near full
// - no flow control: rts idle, overflow lost
// - framing error, then break after frame
// - parity bytes kept, framing bytes dropped
// - parity on/off, even/odd, stop bits
`timescale 1ns/1ps
module dma_serial_port #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // ram port, read data one cycle after mem_rd_o
  output logic [31:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_wr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_rdata_i,
  // serial link
  output logic txd_o,
  input wire logic rxd_i,
  input wire logic cts_n_i,
  output logic rts_n_o
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] RTS_LEVEL = CW'(FIFO_DEPTH - dma_serial_pkg::FLOW_MARGIN);

  // refuse depths that the pointers and the rts level cannot serve
  if (FIFO_DEPTH <= dma_serial_pkg::FLOW_MARGIN || FIFO_DEPTH != (1 << PW)) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two above the flow margin");
  end

  function automatic logic [3:0] frame_bits(input logic par, input logic two);
    frame_bits = dma_serial_pkg::FRAME_BASE_BITS + {3'h0, par} + {3'h0, two};
  endfunction

  // configuration and shadow registers
  logic [3:0] enable_reg;
  logic [15:0] div_reg;
  logic [8:0] cfg_reg;
  logic [31:0] rx_addr_reg, tx_addr_reg;
  logic [15:0] rx_limit_reg, tx_count_reg;
  logic [15:0] rx_amount_reg, tx_amount_reg;
  logic [3:0] err_reg;
  logic [10:0] ev_reg;

  wire en = enable_reg == dma_serial_pkg::ENABLE_ON;
  wire fc_on = cfg_reg[dma_serial_pkg::CFG_FC_BIT];
  wire par_on = cfg_reg[dma_serial_pkg::CFG_PAR_LSB +: 3] == dma_serial_pkg::PARITY_ON;
  wire two_stop = cfg_reg[dma_serial_pkg::CFG_STOP_BIT];
  wire odd_par = cfg_reg[dma_serial_pkg::CFG_ODD_BIT];
  wire [15:0] div_m1 = div_reg - 16'h0001;
  wire [15:0] div_half = {1'b0, div_reg[15:1]};

  // task decode: one write of one fires a task when enabled
  wire task_go = reg_wr_i && reg_wdata_i[0] && en;
  wire t_begin_rx = task_go && reg_addr_i == dma_serial_pkg::TASK_BEGIN_RX;
  wire t_halt_rx = task_go && reg_addr_i == dma_serial_pkg::TASK_HALT_RX;
  wire t_begin_tx = task_go && reg_addr_i == dma_serial_pkg::TASK_BEGIN_TX;
  wire t_halt_tx = task_go && reg_addr_i == dma_serial_pkg::TASK_HALT_TX;
  wire t_drain = task_go && reg_addr_i == dma_serial_pkg::TASK_DRAIN;
  wire wr_err = reg_wr_i && reg_addr_i == dma_serial_pkg::REG_ERR_SRC;

  // event pulses from the engines
  logic p_sent_reg, p_tx_end_reg, p_tx_began_reg, p_tx_halted_reg;
  logic p_rx_end_reg, p_rx_to_reg, p_rx_began_reg, p_arrived_reg;
  logic [3:0] p_err_reg;
  logic cts_prev_reg;
  wire [10:0] ev_set = {p_tx_halted_reg, p_tx_began_reg, p_rx_began_reg, p_rx_to_reg, |p_err_reg,
    p_tx_end_reg, p_sent_reg, p_rx_end_reg, p_arrived_reg,
    cts_n_i && !cts_prev_reg, !cts_n_i && cts_prev_reg};

  wire [10:0] ev_hit;
  genvar gi;
  for (gi = 0; gi < dma_serial_pkg::NUM_EV; gi++) begin : g_ev
    assign ev_hit[gi] = reg_addr_i == dma_serial_pkg::EV_ADDR[gi];
  end
  wire [10:0] ev_clr = (reg_wr_i && !reg_wdata_i[0]) ? ev_hit : 11'h000;

  // register file writes; hardware set wins over software clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      enable_reg <= 4'h0;
      div_reg <= dma_serial_pkg::MIN_BIT_CYCLES;
      cfg_reg <= 9'h000;
      rx_addr_reg <= 32'h0000_0000;
      tx_addr_reg <= 32'h0000_0000;
      rx_limit_reg <= 16'h0000;
      tx_count_reg <= 16'h0000;
      ev_reg <= 11'h000;
      err_reg <= 4'h0;
      cts_prev_reg <= 1'b1;
    end else begin
      cts_prev_reg <= cts_n_i;
      ev_reg <= ev_set | (ev_reg & ~ev_clr);
      err_reg <= p_err_reg | (err_reg & ~(wr_err ? reg_wdata_i[3:0] : 4'h0));
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          dma_serial_pkg::REG_ENABLE: enable_reg <= reg_wdata_i[3:0];
          // bit time below the 1 Mbps floor is raised to it
          dma_serial_pkg::REG_BAUD_DIV: div_reg <= (reg_wdata_i[15:0] < dma_serial_pkg::MIN_BIT_CYCLES) ?
            dma_serial_pkg::MIN_BIT_CYCLES : reg_wdata_i[15:0];
          dma_serial_pkg::REG_CONFIG: cfg_reg <= reg_wdata_i[8:0];
          dma_serial_pkg::REG_RX_ADDR: rx_addr_reg <= reg_wdata_i;
          dma_serial_pkg::REG_RX_LIMIT: rx_limit_reg <= reg_wdata_i[15:0];
          dma_serial_pkg::REG_TX_ADDR: tx_addr_reg <= reg_wdata_i;
          dma_serial_pkg::REG_TX_COUNT: tx_count_reg <= reg_wdata_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    (|ev_hit) ? {31'h0, |(ev_hit & ev_reg)} :
    reg_addr_i == dma_serial_pkg::REG_ERR_SRC ? {28'h0, err_reg} :
    reg_addr_i == dma_serial_pkg::REG_ENABLE ? {28'h0, enable_reg} :
    reg_addr_i == dma_serial_pkg::REG_BAUD_DIV ? {16'h0, div_reg} :
    reg_addr_i == dma_serial_pkg::REG_CONFIG ? {23'h0, cfg_reg} :
    reg_addr_i == dma_serial_pkg::REG_RX_ADDR ? rx_addr_reg :
    reg_addr_i == dma_serial_pkg::REG_RX_LIMIT ? {16'h0, rx_limit_reg} :
    reg_addr_i == dma_serial_pkg::REG_RX_AMOUNT ? {16'h0, rx_amount_reg} :
    reg_addr_i == dma_serial_pkg::REG_TX_ADDR ? tx_addr_reg :
    reg_addr_i == dma_serial_pkg::REG_TX_COUNT ? {16'h0, tx_count_reg} :
    reg_addr_i == dma_serial_pkg::REG_TX_AMOUNT ? {16'h0, tx_amount_reg} : 32'h0000_0000;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) reg_rdata_o <= 32'h0000_0000;
    else reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end

  // receive fifo
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] f_wr_reg, f_rd_reg;
  logic [CW-1:0] f_cnt_reg;
  wire f_empty = f_cnt_reg == '0;
  wire f_full = f_cnt_reg == DEPTH_C;

  // receive control and dma write side
  dma_serial_pkg::rx_state_type rx_state_reg;
  logic [31:0] rx_ptr_reg;
  logic [15:0] rx_lim_reg, rx_fill_reg;
  logic rx_ended_reg;
  logic [21:0] grace_reg;
  logic rx_busy_reg;
  wire rx_dma_state = rx_state_reg inside {dma_serial_pkg::RX_RUN, dma_serial_pkg::RX_GRACE,
    dma_serial_pkg::RX_DRAIN, dma_serial_pkg::RX_FLUSH};
  wire dma_go = rx_dma_state && !f_empty && !rx_ended_reg && rx_fill_reg != rx_lim_reg;
  wire rx_listen = rx_state_reg inside {dma_serial_pkg::RX_RUN, dma_serial_pkg::RX_GRACE};
  wire [3:0] rx_frame = frame_bits(par_on, two_stop);
  wire [21:0] grace_len = 22'(rx_frame * div_reg) * 22'(dma_serial_pkg::GRACE_BYTES);
  logic push;
  logic [7:0] push_data;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_state_reg <= dma_serial_pkg::RX_OFF;
      rx_ptr_reg <= 32'h0000_0000;
      rx_lim_reg <= 16'h0000;
      rx_fill_reg <= 16'h0000;
      rx_amount_reg <= 16'h0000;
      rx_ended_reg <= 1'b1;
      grace_reg <= 22'h000000;
      p_rx_end_reg <= 1'b0;
      p_rx_to_reg <= 1'b0;
      p_rx_began_reg <= 1'b0;
    end else begin
      p_rx_end_reg <= 1'b0;
      p_rx_to_reg <= 1'b0;
      p_rx_began_reg <= 1'b0;
      if (dma_go) rx_fill_reg <= rx_fill_reg + 16'h0001;
      if (t_begin_rx && rx_state_reg inside {dma_serial_pkg::RX_OFF, dma_serial_pkg::RX_RUN}) begin
        rx_ptr_reg <= rx_addr_reg;
        rx_lim_reg <= rx_limit_reg;
        rx_fill_reg <= 16'h0000;
        rx_ended_reg <= 1'b0;
        p_rx_began_reg <= 1'b1;
        rx_state_reg <= dma_serial_pkg::RX_RUN;
      end else begin
        unique case (rx_state_reg)
          dma_serial_pkg::RX_OFF: begin
            if (t_drain) begin
              rx_ptr_reg <= rx_addr_reg;
              rx_lim_reg <= rx_limit_reg;
              rx_fill_reg <= 16'h0000;
              rx_ended_reg <= 1'b0;
              rx_state_reg <= dma_serial_pkg::RX_FLUSH;
            end else if (t_halt_rx) begin
              rx_state_reg <= dma_serial_pkg::RX_TIMEOUT;
            end
          end
          dma_serial_pkg::RX_RUN, dma_serial_pkg::RX_GRACE: begin
            if (!rx_ended_reg && rx_fill_reg == rx_lim_reg) begin
              p_rx_end_reg <= 1'b1;
              rx_amount_reg <= rx_fill_reg;
              rx_fill_reg <= 16'h0000;
              rx_ended_reg <= 1'b1;
            end
            if (rx_state_reg == dma_serial_pkg::RX_RUN) begin
              if (t_halt_rx) begin
                grace_reg <= grace_len;
                rx_state_reg <= dma_serial_pkg::RX_GRACE;
              end
            end else if (grace_reg != 22'h000000) begin
              grace_reg <= grace_reg - 22'h000001;
            end else if (!rx_busy_reg) begin
              rx_state_reg <= dma_serial_pkg::RX_DRAIN;
            end
          end
          dma_serial_pkg::RX_DRAIN: begin
            if (!dma_go) begin
              if (!rx_ended_reg) begin
                p_rx_end_reg <= 1'b1;
                rx_amount_reg <= rx_fill_reg;
                rx_fill_reg <= 16'h0000;
                rx_ended_reg <= 1'b1;
              end
              rx_state_reg <= dma_serial_pkg::RX_TIMEOUT;
            end
          end
          dma_serial_pkg::RX_TIMEOUT: begin
            p_rx_to_reg <= 1'b1;
            rx_state_reg <= dma_serial_pkg::RX_OFF;
          end
          dma_serial_pkg::RX_FLUSH: begin
            if (!dma_go) begin
              p_rx_end_reg <= 1'b1;
              rx_amount_reg <= rx_fill_reg;
              rx_fill_reg <= 16'h0000;
              rx_ended_reg <= 1'b1;
              rx_state_reg <= dma_serial_pkg::RX_OFF;
            end
          end
          default: rx_state_reg <= dma_serial_pkg::RX_OFF;
        endcase
      end
    end
  end

  // fifo pointers; a byte that meets a full fifo is lost
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      f_wr_reg <= '0;
      f_rd_reg <= '0;
      f_cnt_reg <= '0;
    end else begin
      if (push && !f_full) begin
        fifo_mem[f_wr_reg] <= push_data;
        f_wr_reg <= f_wr_reg + 1'b1;
      end
      if (dma_go) f_rd_reg <= f_rd_reg + 1'b1;
      f_cnt_reg <= f_cnt_reg + CW'(push && !f_full) - CW'(dma_go);
    end
  end

  // receive shifter; start bit checked at mid-bit
  logic rx_prev_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [9:0] rx_sh_reg;
  logic [20:0] brk_cnt_reg;
  logic brk_done_reg;
  wire [3:0] rx_last = frame_bits(par_on, 1'b0) - 4'h1;
  wire [9:0] sh_next = {rxd_i, rx_sh_reg[9:1]};
  wire [7:0] rx_byte = par_on ? sh_next[7:0] : sh_next[8:1];
  wire rx_par_bad = par_on && ((^sh_next[8:0]) != odd_par);
  wire [20:0] brk_len = 21'(frame_bits(par_on, 1'b0) * div_reg);
  wire rx_sample = rx_busy_reg && rx_cnt_reg == 16'h0000;
  wire rx_done = rx_sample && rx_bit_reg == rx_last;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_prev_reg <= 1'b1;
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 10'h000;
      brk_cnt_reg <= 21'h000000;
      brk_done_reg <= 1'b0;
      push <= 1'b0;
      push_data <= 8'h00;
      p_arrived_reg <= 1'b0;
      p_err_reg <= 4'h0;
    end else begin
      rx_prev_reg <= rxd_i;
      push <= 1'b0;
      p_arrived_reg <= 1'b0;
      p_err_reg <= 4'h0;
      // a line held low past one frame is a break, after the framing error
      if (rxd_i || !en) begin
        brk_cnt_reg <= 21'h000000;
        brk_done_reg <= 1'b0;
      end else if (!brk_done_reg) begin
        brk_cnt_reg <= brk_cnt_reg + 21'h000001;
        if (brk_cnt_reg == brk_len) begin
          p_err_reg[dma_serial_pkg::ERR_BREAK] <= 1'b1;
          brk_done_reg <= 1'b1;
        end
      end
      if (!rx_busy_reg) begin
        if (rx_listen && rx_prev_reg && !rxd_i) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= div_half;
          rx_bit_reg <= 4'h0;
        end
      end else if (!rx_sample) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else if (rx_bit_reg == 4'h0 && rxd_i) begin
        rx_busy_reg <= 1'b0;
      end else begin
        rx_cnt_reg <= div_m1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        rx_sh_reg <= sh_next;
        if (rx_done) begin
          rx_busy_reg <= 1'b0;
          if (!sh_next[9]) begin
            p_err_reg[dma_serial_pkg::ERR_FRAMING] <= 1'b1;
          end else begin
            push <= 1'b1;
            push_data <= rx_byte;
            p_arrived_reg <= 1'b1;
            p_err_reg[dma_serial_pkg::ERR_PARITY] <= rx_par_bad;
            p_err_reg[dma_serial_pkg::ERR_OVERRUN] <= f_full && !(dma_go && f_cnt_reg == DEPTH_C);
          end
        end
      end
    end
  end

  // transmit engine; ram reads yield to receive writes
  dma_serial_pkg::tx_state_type tx_state_reg;
  logic [31:0] tx_ptr_reg;
  logic [15:0] tx_left_reg;
  logic tx_stop_reg, tx_ended_reg;
  logic [11:0] tx_sh_reg;
  logic [3:0] tx_bit_reg;
  logic [15:0] tx_cnt_reg;
  wire [3:0] tx_last = frame_bits(par_on, two_stop) - 4'h1;
  wire cts_ok = !fc_on || !cts_n_i;
  wire tx_read = tx_state_reg == dma_serial_pkg::TX_FETCH && !tx_stop_reg && !t_halt_tx &&
    tx_left_reg != 16'h0000 && cts_ok && !dma_go;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_state_reg <= dma_serial_pkg::TX_IDLE;
      tx_ptr_reg <= 32'h0000_0000;
      tx_left_reg <= 16'h0000;
      tx_amount_reg <= 16'h0000;
      tx_stop_reg <= 1'b0;
      tx_ended_reg <= 1'b1;
      tx_sh_reg <= 12'hfff;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      p_sent_reg <= 1'b0;
      p_tx_end_reg <= 1'b0;
      p_tx_began_reg <= 1'b0;
      p_tx_halted_reg <= 1'b0;
    end else begin
      p_sent_reg <= 1'b0;
      p_tx_end_reg <= 1'b0;
      p_tx_began_reg <= 1'b0;
      p_tx_halted_reg <= 1'b0;
      if (t_halt_tx && tx_state_reg != dma_serial_pkg::TX_IDLE) tx_stop_reg <= 1'b1;
      unique case (tx_state_reg)
        dma_serial_pkg::TX_IDLE: begin
          if (t_begin_tx) begin
            tx_ptr_reg <= tx_addr_reg;
            tx_left_reg <= tx_count_reg;
            tx_amount_reg <= 16'h0000;
            tx_ended_reg <= 1'b0;
            tx_stop_reg <= 1'b0;
            p_tx_began_reg <= 1'b1;
            tx_state_reg <= dma_serial_pkg::TX_FETCH;
          end else if (t_halt_tx) begin
            p_tx_halted_reg <= 1'b1;
          end
        end
        dma_serial_pkg::TX_FETCH: begin
          if (tx_stop_reg || t_halt_tx) begin
            p_tx_end_reg <= !tx_ended_reg;
            tx_ended_reg <= 1'b1;
            p_tx_halted_reg <= 1'b1;
            tx_stop_reg <= 1'b0;
            tx_state_reg <= dma_serial_pkg::TX_IDLE;
          end else if (tx_left_reg == 16'h0000) begin
            p_tx_end_reg <= 1'b1;
            tx_ended_reg <= 1'b1;
            tx_state_reg <= dma_serial_pkg::TX_IDLE;
          end else if (tx_read) begin
            tx_state_reg <= dma_serial_pkg::TX_WAIT;
          end
        end
        dma_serial_pkg::TX_WAIT: begin
          // data arrives the cycle after the read strobe
          if (!mem_rd_o) begin
            tx_sh_reg <= {2'h3, par_on ? ((^mem_rdata_i) ^ odd_par) : 1'b1, mem_rdata_i, 1'b0};
            tx_bit_reg <= 4'h0;
            tx_cnt_reg <= div_m1;
            tx_state_reg <= dma_serial_pkg::TX_SHIFT;
          end
        end
        dma_serial_pkg::TX_SHIFT: begin
          if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end else if (tx_bit_reg != tx_last) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_cnt_reg <= div_m1;
          end else begin
            p_sent_reg <= 1'b1;
            tx_left_reg <= tx_left_reg - 16'h0001;
            tx_ptr_reg <= tx_ptr_reg + 32'h0000_0001;
            tx_amount_reg <= tx_amount_reg + 16'h0001;
            tx_state_reg <= dma_serial_pkg::TX_FETCH;
          end
        end
        default: tx_state_reg <= dma_serial_pkg::TX_IDLE;
      endcase
    end
  end

  // registered pins and ram strobes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
      rts_n_o <= 1'b1;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= 8'h00;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
    end else begin
      txd_o <= tx_state_reg == dma_serial_pkg::TX_SHIFT ? tx_sh_reg[0] : 1'b1;
      rts_n_o <= !(fc_on && en && rx_state_reg == dma_serial_pkg::RX_RUN && !t_halt_rx &&
        f_cnt_reg < RTS_LEVEL);
      mem_wr_o <= dma_go;
      mem_rd_o <= tx_read;
      mem_wdata_o <= fifo_mem[f_rd_reg];
      mem_addr_o <= dma_go ? rx_ptr_reg + {16'h0000, rx_fill_reg} : tx_ptr_reg;
    end
  end
endmodule // dma_serial_port

// ### test/serial_port_monitor.sv
// Purpose: port checks for the dma serial port
// Assumes: bit time never below 250 cycles
// Notes: config and enable are snooped from register writes
`timescale 1ns/1ps
module serial_port_monitor (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic mem_wr_o,
  input wire logic mem_rd_o,
  input wire logic txd_o,
  input wire logic rts_n_o
);
  logic fc_reg;
  logic en_reg;
  wire cfg_wr = reg_wr_i && reg_addr_i == dma_serial_pkg::REG_CONFIG;
  wire en_wr = reg_wr_i && reg_addr_i == dma_serial_pkg::REG_ENABLE;
  wire halt_rx = reg_wr_i && reg_addr_i == dma_serial_pkg::TASK_HALT_RX && reg_wdata_i[0];
  always_ff @(posedge ref_clk_i) begin
    fc_reg <= rst_i ? 1'b0 : (cfg_wr ? reg_wdata_i[0] : fc_reg);
    en_reg <= rst_i ? 1'b0 : (en_wr ? reg_wdata_i[3:0] == dma_serial_pkg::ENABLE_ON : en_reg);
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_cause: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
    else $error("read data without a read");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 12'hffc |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_one_ram_op: assert property (!(mem_wr_o && mem_rd_o))
    else $error("ram read and write together");
  a_fetch_single: assert property (mem_rd_o |=> !mem_rd_o)
    else $error("ram read longer than one cycle");
  a_bit_hold: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("serial bit too short");
  a_rts_unused: assert property (!fc_reg && !$past(fc_reg) |-> rts_n_o)
    else $error("rts driven without flow control");
  a_rts_on_halt: assert property (halt_rx && fc_reg |-> ##[1:3] rts_n_o)
    else $error("rts still active after halt");
  a_quiet_disabled: assert property (!en_reg && !$past(en_reg) |-> !mem_wr_o && !mem_rd_o)
    else $error("ram access while disabled");
endmodule // serial_port_monitor

bind dma_serial_port serial_port_monitor i_mon (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mem_wr_o, .mem_rd_o, .txd_o, .rts_n_o);

// ### test/far_end_uart.sv
// Purpose: far-end serial transceiver model
// Assumes: same bit time as the port, in clock cycles
// Notes: clear-to-send held active; waits for rts before each byte
`timescale 1ns/1ps
module far_end_uart #(
  parameter int BIT_CYCLES = 250
) (
  // link
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic rts_n_i,
  output logic rxd_o,
  output logic cts_n_o
);
  logic [7:0] got [$];
  logic [7:0] sh;
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    wait (rts_n_i === 1'b0);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk_i);
    end
  endtask
  // sample each bit mid-way, lsb first
  always begin
    @(negedge txd_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_i);
      sh[i] = txd_i;
    end
    got.push_back(sh);
    repeat (BIT_CYCLES) @(posedge clk_i);
  end
endmodule // far_end_uart

// ### test/testbench.sv
// Purpose: self-checking bench for the dma serial port
// Assumes: divisor left at its reset value of 250 cycles
// Notes: ram is a 256-byte model with one-cycle reads
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [31:0] mem_addr_o;
  logic [7:0] mem_wdata_o;
  logic mem_wr_o;
  logic mem_rd_o;
  logic [7:0] mem_rdata_i = 8'h0;
  logic txd_o;
  logic rxd_i;
  logic cts_n_i;
  logic rts_n_o;
  logic [7:0] ram [256];
  logic [31:0] d;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  dma_serial_port i_dut (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .mem_addr_o, .mem_wdata_o, .mem_wr_o, .mem_rd_o, .mem_rdata_i, .txd_o, .rxd_i,
    .cts_n_i, .rts_n_o);
  far_end_uart i_far (.clk_i(ref_clk_i), .txd_i(txd_o), .rts_n_i(rts_n_o), .rxd_o(rxd_i),
    .cts_n_o(cts_n_i));
  always @(posedge ref_clk_i) begin
    if (mem_wr_o) ram[mem_addr_o[7:0]] <= mem_wdata_o;
    mem_rdata_i <= ram[mem_addr_o[7:0]];
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard, well above the longest expected run
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic wait_ev(input int i);
    logic [31:0] v;
    for (int k = 0; k < 60; k++) begin
      rd(dma_serial_pkg::EV_ADDR[i], v);
      if (v[0] === 1'b1) break;
      repeat (400) @(posedge ref_clk_i);
    end
    chk("event flag", v, 32'h1);
  endtask
  initial begin
    ram[8'h10] = 8'ha5;
    ram[8'h11] = 8'h3c;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wr(dma_serial_pkg::REG_ENABLE, 32'h4);
    wr(dma_serial_pkg::REG_CONFIG, 32'h1);
    wr(dma_serial_pkg::REG_TX_ADDR, 32'h10);
    wr(dma_serial_pkg::REG_TX_COUNT, 32'h2);
    wr(dma_serial_pkg::TASK_BEGIN_TX, 32'h1);
    wait_ev(dma_serial_pkg::EV_TX_END);
    chk("tx byte 0", i_far.got[0], 32'ha5);
    chk("tx byte 1", i_far.got[1], 32'h3c);
    rd(dma_serial_pkg::REG_TX_AMOUNT, d);
    chk("tx amount", d, 32'h2);
    wait_ev(dma_serial_pkg::EV_SENT);
    wr(dma_serial_pkg::EV_ADDR[dma_serial_pkg::EV_SENT], 32'h0);
    rd(dma_serial_pkg::EV_ADDR[dma_serial_pkg::EV_SENT], d);
    chk("sent flag cleared", d, 32'h0);
    wr(dma_serial_pkg::REG_RX_ADDR, 32'h40);
    wr(dma_serial_pkg::REG_RX_LIMIT, 32'h2);
    wr(dma_serial_pkg::TASK_BEGIN_RX, 32'h1);
    wait_ev(dma_serial_pkg::EV_RX_BEGAN);
    wr(dma_serial_pkg::REG_RX_ADDR, 32'h80);
    i_far.send(8'h96);
    i_far.send(8'h01);
    wait_ev(dma_serial_pkg::EV_RX_END);
    chk("rx byte 0", ram[8'h40], 32'h96);
    chk("rx byte 1", ram[8'h41], 32'h01);
    rd(dma_serial_pkg::REG_RX_AMOUNT, d);
    chk("rx amount", d, 32'h2);
    wait_ev(dma_serial_pkg::EV_ARRIVED);
    i_far.send(8'h5a);
    wr(dma_serial_pkg::TASK_HALT_RX, 32'h1);
    wait_ev(dma_serial_pkg::EV_RX_TIMEOUT);
    wr(dma_serial_pkg::EV_ADDR[dma_serial_pkg::EV_RX_END], 32'h0);
    wr(dma_serial_pkg::REG_RX_LIMIT, 32'h5);
    wr(dma_serial_pkg::TASK_DRAIN, 32'h1);
    wait_ev(dma_serial_pkg::EV_RX_END);
    chk("drained byte", ram[8'h80], 32'h5a);
    rd(dma_serial_pkg::REG_RX_AMOUNT, d);
    chk("drain amount", d, 32'h1);
    wr(dma_serial_pkg::REG_CONFIG, 32'h1f);
    wr(dma_serial_pkg::EV_ADDR[dma_serial_pkg::EV_TX_END], 32'h0);
    wr(dma_serial_pkg::TASK_BEGIN_TX, 32'h1);
    wait_ev(dma_serial_pkg::EV_TX_END);
    chk("parity frame byte", i_far.got[2], 32'ha5);
    wr(dma_serial_pkg::TASK_HALT_TX, 32'h1);
    wait_ev(dma_serial_pkg::EV_TX_HALTED);
    wr(dma_serial_pkg::REG_ENABLE, 32'h0);
    rd(12'hffc, d);
    chk("unmapped read", d, 32'h0);
    finish_test();
  end
endmodule // testbench
